// >>> rtl/sdcd_decoder.sv
/*
  Command decoder and clock-enable state logic of a four-bank synchronous
  DRAM: decodes sampled command pins, tracks bank and burst state, power
  states, and drives the masked data path.
  Assumes all pins synchronous to clk and a storage array outside that
  takes store strobes and answers col_q with array_rd_data.
*/
`timescale 1ns/1ps
`include "sdcd_cfg.svh"

module sdcd_decoder (
  input wire logic clk, // 40 MHz system clock
  input wire logic sys_rst, // Async reset, high
  input wire logic cke, // Clock enable pin
  input wire sdcd_pkg::sdcd_pins_s cmd_pins, // Chip select and strobes, low active
  input wire logic [1:0] bank_select, // Bank inputs
  input wire logic [`SDCD_ROW_W-1:0] addr, // Address lines
  input wire logic lower_data_mask, // Low byte mask
  input wire logic upper_data_mask, // High byte mask
  input wire logic [`SDCD_DQ_W-1:0] data_bus_in, // Data bus input level
  input wire logic [`SDCD_DQ_W-1:0] array_rd_data, // Storage word at col_q
  output sdcd_pkg::sdcd_cmd_s cmd_q, // Last decoded command
  output logic [`SDCD_BANKS-1:0] bank_active_q, // Bank open flags
  output sdcd_pkg::sdcd_pwr_e pwr_q, // Power state
  output logic burst_active_q, // Burst running
  output logic burst_wr_q, // Burst is a write
  output logic [1:0] burst_bank_q, // Bank of the burst
  output logic [`SDCD_COL_W-1:0] col_q, // Column of last beat
  output logic [`SDCD_ROW_W-1:0] mode_q, // Mode opcode
  output logic store_en_q, // Write beat to storage
  output logic [1:0] store_be_q, // Byte enables to storage
  output logic [`SDCD_DQ_W-1:0] store_data_q, // Data to storage
  output logic [`SDCD_DQ_W-1:0] data_bus_out_q, // Data bus output level
  output logic [1:0] data_bus_oe_q // Data bus byte drive enables
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic sdcd_pkg::sdcd_cmd_e decode(input sdcd_pkg::sdcd_pins_s p,
                                                 input logic ck);
    sdcd_pkg::sdcd_cmd_e c;
    c = sdcd_pkg::CMD_NOP;
    if (p.cs_n) begin
      c = sdcd_pkg::CMD_DESEL;
    end else begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h7: c = sdcd_pkg::CMD_NOP;
        3'h3: c = sdcd_pkg::CMD_ACT;
        3'h2: c = sdcd_pkg::CMD_PRE;
        3'h5: c = sdcd_pkg::CMD_RD;
        3'h4: c = sdcd_pkg::CMD_WR;
        3'h0: c = sdcd_pkg::CMD_MRS;
        3'h1: c = ck ? sdcd_pkg::CMD_AREF : sdcd_pkg::CMD_SREF;
        3'h6: c = sdcd_pkg::CMD_BST;
        default: c = sdcd_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [`SDCD_LEFT_W-1:0] burst_len(
      input logic [`SDCD_MR_BL_MSB:0] code);
    logic [`SDCD_LEFT_W-1:0] n;
    case (code)
      3'h0: n = 4'h1;
      3'h1: n = 4'h2;
      3'h2: n = 4'h4;
      3'h3: n = 4'h8;
      default: n = 4'h1;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  logic cke_prev_q, cke_prev_d;
  logic full_q, full_d;
  logic ap_q, ap_d;
  logic [`SDCD_LEFT_W-1:0] left_q, left_d;
  logic [`SDCD_LEFT_W-1:0] bl;
  logic [`SDCD_BANKS-1:0] bank_active_d;
  logic [`SDCD_COL_W-1:0] col_d;
  logic [`SDCD_ROW_W-1:0] mode_d;
  logic [1:0] burst_bank_d;
  logic burst_active_d, burst_wr_d;
  logic run, exec, nop_like, beat, bl_full;
  sdcd_pkg::sdcd_cmd_e op_now;
  sdcd_pkg::sdcd_cmd_s cmd_d;
  sdcd_pkg::sdcd_pwr_e pwr_d;

  always_comb begin
    op_now = decode(cmd_pins, cke);
    nop_like = (op_now == sdcd_pkg::CMD_NOP) || (op_now == sdcd_pkg::CMD_DESEL);
    run = (pwr_q == sdcd_pkg::PS_RUN) && cke_prev_q;
    exec = run && !cmd_pins.cs_n;
    bl = burst_len(mode_q[`SDCD_MR_BL_MSB:0]);
    bl_full = mode_q[`SDCD_MR_BL_MSB:0] == `SDCD_BL_FULL_CODE;
    cke_prev_d = cke;
    cmd_d.op = run ? op_now : sdcd_pkg::CMD_NONE;
    cmd_d.bank = bank_select;
    cmd_d.addr = addr;
    cmd_d.auto_pre = addr[`SDCD_AP_BIT];
    bank_active_d = bank_active_q;
    mode_d = mode_q;
    pwr_d = pwr_q;
    left_d = left_q;
    full_d = full_q;
    ap_d = ap_q;
    burst_wr_d = burst_wr_q;
    burst_bank_d = burst_bank_q;
    burst_active_d = burst_active_q;
    col_d = col_q;
    beat = 1'b0;

    // Burst advance; frozen while suspended
    if (burst_active_q && run) begin
      beat = 1'b1;
      col_d = col_q + 9'h001;
      if (!full_q) begin
        left_d = left_q - 4'h1;
        if (left_q == 4'h1) begin
          burst_active_d = 1'b0;
          if (ap_q) begin
            bank_active_d[burst_bank_q] = 1'b0;
          end
        end
      end
    end

    if (exec) begin
      case (op_now)
        sdcd_pkg::CMD_ACT: begin
          bank_active_d[bank_select] = 1'b1;
        end
        sdcd_pkg::CMD_PRE: begin
          if (addr[`SDCD_AP_BIT]) begin
            bank_active_d = '0;
          end else begin
            bank_active_d[bank_select] = 1'b0;
          end
          if (addr[`SDCD_AP_BIT] || bank_select == burst_bank_q) begin
            burst_active_d = 1'b0;
          end
        end
        sdcd_pkg::CMD_RD, sdcd_pkg::CMD_WR: begin
          // Relies on the controller only addressing an open bank
          beat = 1'b1;
          burst_wr_d = !cmd_pins.we_n;
          burst_bank_d = bank_select;
          col_d = addr[`SDCD_COL_W-1:0];
          full_d = bl_full;
          left_d = bl - 4'h1;
          ap_d = addr[`SDCD_AP_BIT] && !bl_full;
          burst_active_d = bl_full || (bl != 4'h1);
          if (!burst_active_d && ap_d) begin
            bank_active_d[bank_select] = 1'b0;
          end
        end
        sdcd_pkg::CMD_BST: begin
          burst_active_d = 1'b0;
        end
        sdcd_pkg::CMD_MRS: begin
          if (bank_active_q == '0) begin
            mode_d = addr;
          end
        end
        default: begin
        end
      endcase
    end

    case (pwr_q)
      sdcd_pkg::PS_RUN: begin
        if (cke_prev_q && !cke) begin
          if (burst_active_q) begin
            pwr_d = sdcd_pkg::PS_SUSP;
          end else if (op_now == sdcd_pkg::CMD_SREF && bank_active_q == '0) begin
            pwr_d = sdcd_pkg::PS_SREF;
          end else if (nop_like) begin
            pwr_d = sdcd_pkg::PS_PDOWN;
          end
        end
      end
      sdcd_pkg::PS_SUSP: begin
        if (!cke_prev_q && cke) begin
          pwr_d = sdcd_pkg::PS_RUN;
        end
      end
      sdcd_pkg::PS_PDOWN, sdcd_pkg::PS_SREF: begin
        if (!cke_prev_q && cke && nop_like) begin
          pwr_d = sdcd_pkg::PS_RUN;
        end
      end
      default: pwr_d = sdcd_pkg::PS_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cke_prev_q <= 1'b0;
      cmd_q <= '0;
      bank_active_q <= '0;
      pwr_q <= sdcd_pkg::PS_RUN;
      mode_q <= `SDCD_MODE_RST;
      left_q <= '0;
      full_q <= 1'b0;
      ap_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_bank_q <= 2'h0;
      burst_active_q <= 1'b0;
      col_q <= '0;
    end else begin
      cke_prev_q <= cke_prev_d;
      cmd_q <= cmd_d;
      bank_active_q <= bank_active_d;
      pwr_q <= pwr_d;
      mode_q <= mode_d;
      left_q <= left_d;
      full_q <= full_d;
      ap_q <= ap_d;
      burst_wr_q <= burst_wr_d;
      burst_bank_q <= burst_bank_d;
      burst_active_q <= burst_active_d;
      col_q <= col_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Masked data path

  sdcd_dq_mask u_dq (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_beat(beat && burst_wr_d),
    .rd_beat(beat && !burst_wr_d),
    .dqm({upper_data_mask, lower_data_mask}),
    .din(data_bus_in),
    .rd_word(array_rd_data),
    .store_en_q(store_en_q),
    .store_be_q(store_be_q),
    .store_data_q(store_data_q),
    .dout_q(data_bus_out_q),
    .doe_q(data_bus_oe_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_cke_fall;
    cke_prev_q && !cke;
  endsequence

  sequence s_cke_rise;
    !cke_prev_q && cke;
  endsequence

  a_nop_decode: assert property (
    run && cmd_pins == 4'h7 |=> cmd_q.op == sdcd_pkg::CMD_NOP)
    else $error("nop pattern not decoded as nop");

  a_deselect_masked: assert property (
    cmd_pins.cs_n |=> cmd_q.op inside {sdcd_pkg::CMD_DESEL, sdcd_pkg::CMD_NONE}
                      && $stable(mode_q))
    else $error("command acted on while chip select high");

  a_column_read: assert property (
    exec && op_now == sdcd_pkg::CMD_RD
    |=> !burst_wr_q && col_q == $past(addr[`SDCD_COL_W-1:0])
        && cmd_q.auto_pre == $past(addr[`SDCD_AP_BIT]))
    else $error("read start, column or precharge flag wrong");

  a_write_store: assert property (
    exec && op_now == sdcd_pkg::CMD_WR |=> burst_wr_q && store_en_q)
    else $error("write command did not store its first beat");

  a_activate_bank: assert property (
    exec && op_now == sdcd_pkg::CMD_ACT |=> bank_active_q[$past(bank_select)])
    else $error("activated bank not marked open");

  a_precharge_all: assert property (
    exec && op_now == sdcd_pkg::CMD_PRE && addr[`SDCD_AP_BIT] |=> bank_active_q == '0)
    else $error("precharge all left a bank open");

  a_burst_stop: assert property (
    exec && op_now == sdcd_pkg::CMD_BST |=> !burst_active_q)
    else $error("burst stop did not end the burst");

  a_suspend_entry: assert property (
    pwr_q == sdcd_pkg::PS_RUN && burst_active_q ##0 s_cke_fall
    |=> pwr_q == sdcd_pkg::PS_SUSP ##1 (pwr_q != sdcd_pkg::PS_SUSP || $stable(col_q)))
    else $error("burst did not enter or hold clock suspend");

  a_suspend_exit: assert property (
    pwr_q == sdcd_pkg::PS_SUSP ##0 s_cke_rise |=> pwr_q == sdcd_pkg::PS_RUN)
    else $error("clock suspend did not end on clock enable rise");

  a_pdown_entry: assert property (
    pwr_q == sdcd_pkg::PS_RUN && !burst_active_q && nop_like ##0 s_cke_fall
    |=> pwr_q == sdcd_pkg::PS_PDOWN)
    else $error("power-down not entered");

  a_pdown_exit: assert property (
    pwr_q inside {sdcd_pkg::PS_PDOWN, sdcd_pkg::PS_SREF} && !nop_like ##0 s_cke_rise
    |=> pwr_q == $past(pwr_q))
    else $error("low-power exit taken without nop or deselect");

  a_self_refresh: assert property (
    exec && op_now == sdcd_pkg::CMD_SREF && bank_active_q == '0 && !burst_active_q
    |=> pwr_q == sdcd_pkg::PS_SREF)
    else $error("self-refresh not entered");

endmodule

// >>> rtl/sdcd_cfg.svh
/*
  Constants of the synchronous DRAM command decoder: field positions,
  widths, reset values and latencies.
  Assumes inclusion by bare name from rtl/ files; definitions only.
*/
// What this block does
// - Every command input is sampled on the rising clock edge.
// - Chip select low, row strobe high, column strobe low starts column access.
// - In a column access, write enable low means write, high means read.
// - Row low, column high: write enable high activates, low precharges.
// - Data masks gate read output drivers and block write data storage.
// - Read and write data move on rising edges over the two-way bus.
// - Each command is qualified by current and previous clock-enable samples.
// - Activate marks chosen bank open; precharge one bank, or all if A10.
// - Column from A0..A8; A10 high requests auto precharge after the burst, except for full-page bursts.
// - Burst stop ends a running burst of any length including full page.
// - Power-down is never entered while a burst is in progress.
// - Clock enable falling during a burst enters clock suspend instead.
// - Clock suspend entered from active on previous high, current low.
// - Clock suspend ends on previous low, current high; commands ignored.
// - Power-down entered outside bursts on clock-enable fall with nop or deselect.
// - Power-down and self-refresh exit on clock-enable rise with nop or deselect.
// - Idle refresh: auto if clock enable high, self if low; all low sets mode.
// - All strobes high with chip select low is nop; chip select high deselects.
// - Data mask low enables write data and outputs; high masks both.
// - Commands are ignored on any edge where chip select is high.
`ifndef SDCD_CFG_SVH
`define SDCD_CFG_SVH

`define SDCD_ROW_W 13
`define SDCD_COL_W 9
`define SDCD_DQ_W 16
`define SDCD_LEFT_W 4
`define SDCD_AP_BIT 10
`define SDCD_BANKS 4
`define SDCD_MR_BL_MSB 2
`define SDCD_BL_FULL_CODE 3'h7
`define SDCD_MODE_RST 13'h0000
`define SDCD_DQM_RD_LAT 2

`endif

// >>> rtl/sdcd_pkg.sv
/*
  Types of the synchronous DRAM command decoder: commands, power states
  and the command pin and decoded command carriers.
  Assumes sdcd_cfg.svh is reachable by bare name.
*/
`include "sdcd_cfg.svh"

package sdcd_pkg;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_DESEL = 4'h1,
    CMD_NOP = 4'h2,
    CMD_ACT = 4'h3,
    CMD_PRE = 4'h4,
    CMD_RD = 4'h5,
    CMD_WR = 4'h6,
    CMD_MRS = 4'h7,
    CMD_AREF = 4'h8,
    CMD_SREF = 4'h9,
    CMD_BST = 4'ha
  } sdcd_cmd_e;

  typedef enum logic [1:0] {
    PS_RUN = 2'h0,
    PS_PDOWN = 2'h1,
    PS_SUSP = 2'h2,
    PS_SREF = 2'h3
  } sdcd_pwr_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdcd_pins_s;

  typedef struct packed {
    sdcd_cmd_e op;
    logic [1:0] bank;
    logic [`SDCD_ROW_W-1:0] addr;
    logic auto_pre;
  } sdcd_cmd_s;

endpackage

// >>> rtl/sdcd_dq_mask.sv
/*
  Data mask stage: gates storage of write data and the read output drivers
  with the per-byte masks.
  Assumes beat strobes from the decoder and a storage word that is valid
  the cycle after a read beat.
*/
`timescale 1ns/1ps
`include "sdcd_cfg.svh"

module sdcd_dq_mask (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic wr_beat, // Write beat on this edge
  input wire logic rd_beat, // Read beat on this edge
  input wire logic [1:0] dqm, // Upper, lower mask
  input wire logic [`SDCD_DQ_W-1:0] din, // Data bus input
  input wire logic [`SDCD_DQ_W-1:0] rd_word, // Word from storage
  output logic store_en_q, // Write beat done
  output logic [1:0] store_be_q, // Bytes to store
  output logic [`SDCD_DQ_W-1:0] store_data_q, // Data to store
  output logic [`SDCD_DQ_W-1:0] dout_q, // Data bus output
  output logic [1:0] doe_q // Byte output enables
);

  // Mask of the read beat edge gates the data seen two edges later
  logic [1:0] dqm_pipe_q [`SDCD_DQM_RD_LAT-1];
  logic [1:0] dqm_pipe_d [`SDCD_DQM_RD_LAT-1];
  logic rd_q, rd_d;
  logic store_en_d;
  logic [1:0] store_be_d, doe_d;
  logic [`SDCD_DQ_W-1:0] store_data_d, dout_d;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    dqm_pipe_d[0] = dqm;
    for (int i = 1; i < `SDCD_DQM_RD_LAT-1; i++) begin
      dqm_pipe_d[i] = dqm_pipe_q[i-1];
    end
    rd_d = rd_beat;
    store_en_d = wr_beat;
    store_be_d = wr_beat ? ~dqm : 2'h0;
    store_data_d = wr_beat ? din : store_data_q;
    dout_d = rd_q ? rd_word : dout_q;
    doe_d = rd_q ? ~dqm_pipe_q[`SDCD_DQM_RD_LAT-2] : 2'h0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `SDCD_DQM_RD_LAT-1; i++) begin
        dqm_pipe_q[i] <= 2'h3;
      end
      rd_q <= 1'b0;
      store_en_q <= 1'b0;
      store_be_q <= 2'h0;
      store_data_q <= '0;
      dout_q <= '0;
      doe_q <= 2'h0;
    end else begin
      dqm_pipe_q <= dqm_pipe_d;
      rd_q <= rd_d;
      store_en_q <= store_en_d;
      store_be_q <= store_be_d;
      store_data_q <= store_data_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_write_mask_gate: assert property (
    wr_beat |=> store_en_q && store_be_q == ~$past(dqm))
    else $error("write byte enables do not follow the data mask");

  a_read_drive_gate: assert property (
    rd_beat && dqm == 2'h3 |=> ##1 doe_q == 2'h0)
    else $error("read output driven while masked");

endmodule

// >>> bench/sdcd_ctrl_bfm.sv
/*
  Controller-side model: resolves the data bus wire and holds the storage
  array behind the decoder.
  Assumes store strobes and col_q come straight from the decoder.
*/
`timescale 1ns/1ps

module sdcd_ctrl_bfm (
  input wire logic clk, // Clock
  input wire logic [15:0] dev_out, // Device drive value
  input wire logic [1:0] dev_oe, // Device byte enables
  input wire logic [15:0] host_data, // Controller write data
  input wire logic host_drive, // Controller drives bus
  input wire logic st_en, // Write beat strobe
  input wire logic [1:0] st_be, // Byte enables
  input wire logic [15:0] st_data, // Data to store
  input wire logic [8:0] col, // Addressed column
  output logic [15:0] bus, // Resolved bus level
  output logic [15:0] rd_word // Word at column
);
  logic [15:0] mem [512];
  logic [15:0] last_q = 16'h0000;

  initial for (int i = 0; i < 512; i++) mem[i] = 16'(i);

  // Undriven bytes show the inverse of their last level
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      bus[b*8+:8] = dev_oe[b] ? dev_out[b*8+:8] :
                    host_drive ? host_data[b*8+:8] : ~last_q[b*8+:8];
    end
  end

  assign rd_word = mem[col];

  always @(posedge clk) begin
    last_q <= bus;
    for (int b = 0; b < 2; b++) begin
      if (st_en && st_be[b]) begin
        mem[col][b*8+:8] <= st_data[b*8+:8];
      end
    end
  end
endmodule

// >>> bench/tb_top.sv
/*
  Self-checking bench of the command decoder against a cycle model.
  Assumes sdcd_pkg and sdcd_ctrl_bfm are compiled first.
*/
`timescale 1ns/1ps

module tb_top;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] MRS = 4'h0, REF = 4'h1, BST = 4'h6, DES = 4'hf;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cke = 1'b0;
  sdcd_pkg::sdcd_pins_s pins = DES;
  logic [1:0] bank_select = 2'h0;
  logic [12:0] addr = 13'h0000;
  logic [1:0] dm = 2'h0;
  logic [15:0] host_data = 16'h0000;
  logic host_drive = 1'b0;
  logic [15:0] bus, rd_word, store_data_q, dout;
  sdcd_pkg::sdcd_cmd_s cmd_q;
  sdcd_pkg::sdcd_pwr_e pwr_q;
  logic [3:0] bank_active_q;
  logic burst_active_q, store_en_q;
  logic [1:0] store_be_q, doe;
  logic [1:0] burst_bank;
  logic [8:0] col_q;
  logic [12:0] mode_q;
  integer errors = 0;
  integer check_count = 0;
  integer seed = 32'h35f3f996;
  logic [15:0] exp_mem [512];
  sdcd_pkg::sdcd_cmd_e m_op;
  sdcd_pkg::sdcd_pwr_e m_pwr;
  logic [3:0] m_bank;
  logic [12:0] m_mode;
  logic m_pcke, m_ap, run, nopd;
  integer m_rem, m_bb, r0;

  always #12.5 clk = ~clk;

  sdcd_decoder dut (
    .clk(clk), .sys_rst(sys_rst), .cke(cke), .cmd_pins(pins), .bank_select(bank_select),
    .addr(addr), .lower_data_mask(dm[0]), .upper_data_mask(dm[1]), .data_bus_in(bus),
    .array_rd_data(rd_word), .cmd_q(cmd_q), .bank_active_q(bank_active_q), .pwr_q(pwr_q),
    .burst_active_q(burst_active_q), .burst_wr_q(), .burst_bank_q(burst_bank), .col_q(col_q),
    .mode_q(mode_q), .store_en_q(store_en_q), .store_be_q(store_be_q),
    .store_data_q(store_data_q), .data_bus_out_q(dout), .data_bus_oe_q(doe));

  sdcd_ctrl_bfm ctrl (
    .clk(clk), .dev_out(dout), .dev_oe(doe), .host_data(host_data), .host_drive(host_drive),
    .st_en(store_en_q), .st_be(store_be_q), .st_data(store_data_q), .col(col_q),
    .bus(bus), .rd_word(rd_word));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp_op(input sdcd_pkg::sdcd_cmd_e got, input sdcd_pkg::sdcd_cmd_e exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected op at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pwr(input sdcd_pkg::sdcd_pwr_e got, input sdcd_pkg::sdcd_pwr_e exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected power state at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic sdcd_pkg::sdcd_cmd_e op_of(input logic [2:0] rcw, input logic ck);
    case (rcw)
      3'h7: op_of = sdcd_pkg::CMD_NOP;
      3'h3: op_of = sdcd_pkg::CMD_ACT;
      3'h2: op_of = sdcd_pkg::CMD_PRE;
      3'h5: op_of = sdcd_pkg::CMD_RD;
      3'h4: op_of = sdcd_pkg::CMD_WR;
      3'h0: op_of = sdcd_pkg::CMD_MRS;
      3'h1: op_of = ck ? sdcd_pkg::CMD_AREF : sdcd_pkg::CMD_SREF;
      default: op_of = sdcd_pkg::CMD_BST;
    endcase
  endfunction

  function automatic integer bl_of(input logic [2:0] code);
    case (code)
      3'h1: bl_of = 2;
      3'h2: bl_of = 4;
      3'h3: bl_of = 8;
      3'h7: bl_of = 0;
      default: bl_of = 1;
    endcase
  endfunction

  // Cycle model of decode, bank, burst and power state
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      m_op = sdcd_pkg::CMD_NONE;
      m_pwr = sdcd_pkg::PS_RUN;
      m_bank = 4'h0;
      m_mode = 13'h0000;
      m_pcke = 1'b0;
      m_ap = 1'b0;
      m_rem = 0;
      m_bb = 0;
    end else begin
      run = m_pwr == sdcd_pkg::PS_RUN && m_pcke;
      nopd = pins.cs_n || pins[2:0] == 3'h7;
      r0 = m_rem;
      m_op = sdcd_pkg::CMD_NONE;
      if (run) begin
        m_op = pins.cs_n ? sdcd_pkg::CMD_DESEL : op_of(pins[2:0], cke);
        if (m_rem > 0)
          m_rem--;
        case (m_op)
          sdcd_pkg::CMD_ACT: m_bank[bank_select] = 1'b1;
          sdcd_pkg::CMD_PRE: begin
            m_bank = addr[10] ? 4'h0 : m_bank & ~(4'h1 << bank_select);
            if (addr[10] || bank_select == m_bb)
              m_rem = 0;
          end
          sdcd_pkg::CMD_RD, sdcd_pkg::CMD_WR: begin
            m_rem = bl_of(m_mode[2:0]) - 1;
            m_bb = bank_select;
            m_ap = addr[10] && m_mode[2:0] != 3'h7;
          end
          sdcd_pkg::CMD_BST: m_rem = 0;
          sdcd_pkg::CMD_MRS: if (m_bank == 4'h0) m_mode = addr;
          default: ;
        endcase
        if (m_ap && m_rem == 0)
          m_bank[m_bb] = 1'b0;
        if (m_rem == 0)
          m_ap = 1'b0;
      end
      if (m_pwr == sdcd_pkg::PS_RUN && m_pcke && !cke) begin
        if (r0 != 0)
          m_pwr = sdcd_pkg::PS_SUSP;
        else if (nopd)
          m_pwr = sdcd_pkg::PS_PDOWN;
        else if (m_op == sdcd_pkg::CMD_SREF && m_bank == 4'h0)
          m_pwr = sdcd_pkg::PS_SREF;
      end else if (m_pwr != sdcd_pkg::PS_RUN && !m_pcke && cke) begin
        if (m_pwr == sdcd_pkg::PS_SUSP || nopd)
          m_pwr = sdcd_pkg::PS_RUN;
      end
      m_pcke = cke;
    end
  end

  always @(negedge clk) begin
    if (!sys_rst) begin
      cmp_op(cmd_q.op, m_op);
      cmp_pwr(pwr_q, m_pwr);
      cmp_val(bank_active_q, m_bank);
      cmp_val(burst_active_q, m_rem != 0);
      cmp_val(burst_bank, 16'(m_bb));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic drv(input logic [3:0] p, input logic [1:0] ba, input logic [12:0] a,
                     input logic [1:0] m);
    @(negedge clk);
    pins = p;
    bank_select = ba;
    addr = a;
    dm = m;
  endtask

  task automatic wr_burst(input logic [1:0] ba, input logic [8:0] c, input integer n,
                          input logic ap, input logic full);
    logic [15:0] d [9];
    logic [15:0] bm;
    logic [1:0] m [9];
    for (int i = 0; i <= n; i++) begin
      drv(i == 0 ? WR : (i == n && full) ? BST : NOP, ba, {2'h0, ap, 1'b0, c},
          i < n ? 2'($random(seed)) : 2'h0);
      m[i] = dm;
      d[i] = 16'($random(seed));
      host_data = d[i];
      host_drive = i < n;
      if (i > 0) begin
        bm = {{8{~m[i-1][1]}}, {8{~m[i-1][0]}}};
        cmp_val(store_en_q, 16'h1);
        cmp_val(store_be_q, {bm[8], bm[0]});
        cmp_val(store_data_q & bm, d[i-1] & bm);
        cmp_val(col_q, 16'(c + i - 1));
        exp_mem[c+i-1] = (exp_mem[c+i-1] & ~bm) | (d[i-1] & bm);
      end
    end
  endtask

  task automatic rd_burst(input logic [1:0] ba, input logic [8:0] c, input integer n,
                          input logic ap, input logic full);
    logic [1:0] m [11];
    logic [15:0] bm;
    for (int i = 0; i <= n + 2; i++) begin
      drv(i == 0 ? RD : (i == n && full) ? BST : NOP, ba, {2'h0, ap, 1'b0, c},
          i < n ? 2'($random(seed)) : 2'h0);
      m[i] = dm;
      if (i >= 2 && i < n + 2) begin
        bm = {{8{~m[i-2][1]}}, {8{~m[i-2][0]}}};
        cmp_val(doe, {bm[8], bm[0]});
        cmp_val(dout & bm, exp_mem[c+i-2] & bm);
      end else if (i == n + 2 && !full) begin
        cmp_val(doe, 16'h0);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    errors++;
    complete_run;
  end

  initial begin
    logic [2:0] codes [5];
    logic [1:0] ba;
    logic [8:0] c;
    integer n;
    codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    for (int i = 0; i < 512; i++) exp_mem[i] = 16'(i);
    repeat (20) @(posedge clk);
    @(negedge clk);
    sys_rst <= 1'b0;
    cke = 1'b1;
    repeat (2) drv(NOP, 2'h0, 13'h0000, 2'h0);
    for (int k = 0; k < 5; k++) begin
      n = codes[k] == 3'h7 ? 6 : bl_of(codes[k]);
      ba = 2'($random(seed));
      c = 9'($random(seed)) & 9'h0f8;
      drv(MRS, 2'h0, {10'h0, codes[k]}, 2'h0);
      drv(NOP, 2'h0, 13'h0000, 2'h0);
      cmp_val(mode_q, {10'h0, codes[k]});
      drv(ACT, ba, 13'h0123, 2'h0);
      wr_burst(ba, c, n, codes[k] == 3'h2, codes[k] == 3'h7);
      drv(codes[k] == 3'h2 ? ACT : NOP, ba, 13'h0123, 2'h0);
      rd_burst(ba, c, n, codes[k] == 3'h1, codes[k] == 3'h7);
      drv(PRE, 2'h0, 13'h0400, 2'h0);
    end
    drv(MRS, 2'h0, 13'h0003, 2'h0);
    drv(ACT, 2'h1, 13'h0000, 2'h0);
    drv(RD, 2'h1, 13'h0010, 2'h0);
    drv(NOP, 2'h0, 13'h0000, 2'h0);
    cke = 1'b0;
    repeat (3) drv(NOP, 2'h0, 13'h0000, 2'h0);
    drv(ACT, 2'h2, 13'h0000, 2'h0);
    cke = 1'b1;
    repeat (8) drv(NOP, 2'h0, 13'h0000, 2'h0);
    drv(PRE, 2'h0, 13'h0400, 2'h0);
    drv(DES, 2'h0, 13'h0000, 2'h0);
    cke = 1'b0;
    drv(NOP, 2'h0, 13'h0000, 2'h0);
    drv(ACT, 2'h0, 13'h0000, 2'h0);
    cke = 1'b1;
    drv(NOP, 2'h0, 13'h0000, 2'h0);
    cke = 1'b0;
    drv(NOP, 2'h0, 13'h0000, 2'h0);
    cke = 1'b1;
    drv(REF, 2'h0, 13'h0000, 2'h0);
    cke = 1'b0;
    repeat (2) drv(NOP, 2'h0, 13'h0000, 2'h0);
    drv(DES, 2'h0, 13'h0000, 2'h0);
    cke = 1'b1;
    drv(REF, 2'h0, 13'h0000, 2'h0);
    repeat (20) drv({1'b1, 3'($random(seed))}, 2'($random(seed)), 13'($random(seed)),
                    2'($random(seed)));
    sys_rst <= 1'b1;
    repeat (2) drv(NOP, 2'h0, 13'h0000, 2'h0);
    sys_rst <= 1'b0;
    repeat (3) drv(NOP, 2'h0, 13'h0000, 2'h0);
    complete_run;
  end
endmodule
